// ### inc/hspc_pkg.sv
// constants and types shared by the fast pulse counter
package hspc_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] ADDR_FUNC = 8'h00;
    localparam logic [7:0] ADDR_SP1 = 8'h04;
    localparam logic [7:0] ADDR_CMP1_HI = 8'h08;
    localparam logic [7:0] ADDR_SP2 = 8'h0c;
    localparam logic [7:0] ADDR_CMP2_HI = 8'h10;
    localparam logic [7:0] ADDR_CNT1 = 8'h14;
    localparam logic [7:0] ADDR_CNT2 = 8'h18;
    localparam logic [7:0] ADDR_FLAGS = 8'h1c;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // flag register bit positions
    localparam int unsigned F_GATE1 = 0;
    localparam int unsigned F_IRQEN1 = 1;
    localparam int unsigned F_PRESET1 = 3;
    localparam int unsigned F_GATE2 = 8;
    localparam int unsigned F_IRQEN2 = 9;
    localparam int unsigned F_PRESET2 = 11;
    localparam logic [15:0] FLAG_MASK = 16'h0b0b;
    // function selection codes, top bit is don't care
    localparam logic [15:0] CODE_MASK = 16'h7fff;
    localparam logic [15:0] CODE_UP1 = 16'h1003;
    localparam logic [15:0] CODE_UP2 = 16'h2003;
    localparam logic [15:0] CODE_UP12 = 16'h3003;
    localparam logic [15:0] CODE_SPD1 = 16'h1403;
    localparam logic [15:0] CODE_SPD2 = 16'h2403;
    localparam logic [15:0] CODE_SPD12 = 16'h3403;
    localparam logic [15:0] CODE_QUAD = 16'h0803;
    // sampling time unit and its cycle count
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned SAMPLE_UNIT_NS = 10_000_000;
    localparam int unsigned SAMPLE_UNIT_CYC = SAMPLE_UNIT_NS / CLK_PERIOD_NS;
    localparam logic [6:0] SAMPLE_MIN = 7'h01;
    localparam logic [6:0] SAMPLE_MAX = 7'h64;
    localparam int unsigned TICK_W = 20;
    typedef enum logic [1:0] {
        HSPC_MODE_OFF = 2'b00,
        HSPC_MODE_UP = 2'b01,
        HSPC_MODE_SPEED = 2'b11,
        HSPC_MODE_QUAD = 2'b10
    } hspc_mode_t;
endpackage : hspc_pkg

// ### inc/hspc_pin_if.sv
// synchronised pin level and its edges
`timescale 1ns/100ps
interface hspc_pin_if;
    logic level;
    logic prev;
    logic rise;
    logic fall;
    modport src (output level, output prev, output rise, output fall);
    modport dst (input level, input prev, input rise, input fall);
endinterface : hspc_pin_if

// ### verilog/hspc_sync.sv
// two-flop pin synchroniser with edge detection
`timescale 1ns/100ps
module hspc_sync (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic pin,
    hspc_pin_if.src o
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } hspc_sync_t;
    hspc_sync_t q;
    hspc_sync_t d;

    always_comb begin
        d = q;
        d.s1 = pin;
        d.s2 = q.s1;
        d.s3 = q.s2;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end

    // s1 feeds only s2; edges come from s2/s3 so one edge counts once
    assign o.level = q.s2;
    assign o.prev = q.s3;
    assign o.rise = q.s2 & ~q.s3;
    assign o.fall = ~q.s2 & q.s3;
endmodule : hspc_sync

// ### verilog/hspc_top.sv
// two-channel fast pulse counter with AXI4-Lite registers
//
// Overview of operation
// - up mode: gate on, each count input rising edge adds one
// - up mode: reaching set value clears count, interrupts if enabled
// - up and quadrature modes: reset input on holds count at zero
// - counting only with gate on; gate falling clears count
// - up mode: set value latched as limit when gate rises
// - up mode: preset with gate off loads count from set value
// - up count and set value are unsigned 16-bit
// - each up channel owns inputs, words, flags and interrupt
// - inputs of an unused channel stay plain digital inputs
// - speed mode: rising edges per period go to hold value
// - speed mode: runs with gate on; hold cleared while off
// - sampling period is setting 1 to 100 times 10 ms
// - hold value unsigned 16-bit; speed mode never interrupts
// - quadrature: up when A leads B, down when B leads
// - quadrature: every edge of both phases counts, four per cycle
// - quadrature: count hitting compare 1 or 2 raises interrupt
// - quadrature: preset 1 or 2 with gate off loads compare
// - compare values may be written at any time
// - quadrature count and compares are signed 32-bit word pairs
// - code 1003h selects up ch1, 1403h speed ch1
// - function selection honoured only once, on first write
// - code 0803h selects quadrature using A, B and reset 1
`timescale 1ns/100ps
module hspc_top #(
    parameter int unsigned UNIT_CYCLES = hspc_pkg::SAMPLE_UNIT_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic ch1_count_or_phase_a_input,
    input wire logic ch2_count_or_phase_b_input,
    input wire logic ch1_reset_input,
    input wire logic ch2_reset_input,
    output logic [1:0] irq_program,
    output logic [3:0] gp_inputs
);
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic sel_done;
        logic [15:0] func;
        hspc_pkg::hspc_mode_t mode;
        logic [1:0] chen;
        logic [15:0] flags;
        logic [1:0] gate_q;
        logic [1:0] preset_q;
        logic [1:0][15:0] sp;
        logic [1:0][15:0] hi;
        logic [1:0][15:0] limit;
        logic [1:0][15:0] cnt;
        logic [1:0][15:0] acc;
        logic [1:0][19:0] tick;
        logic [1:0][6:0] per;
        logic [1:0] irq;
        logic [3:0] gp;
    } hspc_state_t;

    hspc_state_t q;
    hspc_state_t d;
    logic [3:0] pins;
    logic [3:0] lvl;
    logic [3:0] prv;
    logic [3:0] rise;

    assign pins = {ch2_reset_input, ch1_reset_input,
                   ch2_count_or_phase_b_input, ch1_count_or_phase_a_input};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        hspc_pin_if pif ();
        hspc_sync u_sync (
            .aclk(aclk),
            .aresetn(aresetn),
            .ce(ce),
            .pin(pins[g]),
            .o(pif)
        );
        assign lvl[g] = pif.level;
        assign prv[g] = pif.prev;
        assign rise[g] = pif.rise;
    end

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] data,
                                            input logic [3:0] strb);
        merge16 = {strb[1] ? data[15:8] : old[15:8],
                   strb[0] ? data[7:0] : old[7:0]};
    endfunction : merge16

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a <= hspc_pkg::ADDR_STATUS) && (a[1:0] == 2'b00);
    endfunction : mapped

    // frozen bus while ce is low: valids and readies drop together
    assign awready = ce & ~q.aw_got & ~q.bvalid;
    assign wready = ce & ~q.w_got & ~q.bvalid;
    assign bvalid = ce & q.bvalid;
    assign bresp = q.bresp;
    assign arready = ce & ~q.rvalid;
    assign rvalid = ce & q.rvalid;
    assign rresp = q.rresp;
    assign rdata = q.rdata;
    assign irq_program = q.irq;
    assign gp_inputs = q.gp;

    always_comb begin
        logic [15:0] code;
        logic [15:0] nxt;
        logic [31:0] qcnt;
        logic [31:0] qnxt;
        logic [31:0] cmp1;
        logic [31:0] cmp2;
        logic [6:0] setting;
        logic [3:0] taken;
        logic gate;
        logic gate_fall;
        logic gate_rise;
        logic pre_rise;
        logic a_edge;
        logic b_edge;
        code = '0;
        nxt = '0;
        qcnt = {q.cnt[1], q.cnt[0]};
        qnxt = qcnt;
        cmp1 = {q.hi[0], q.sp[0]};
        cmp2 = {q.hi[1], q.sp[1]};
        setting = '0;
        taken = '0;
        gate = 1'b0;
        gate_fall = 1'b0;
        gate_rise = 1'b0;
        pre_rise = 1'b0;
        a_edge = 1'b0;
        b_edge = 1'b0;
        d = q;
        d.irq = '0;

        if (awvalid && awready) begin
            d.aw_got = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            d.w_got = 1'b1;
            d.w_data = wdata;
            d.w_strb = wstrb;
        end
        if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rresp = mapped(araddr) ? hspc_pkg::RESP_OKAY
                                     : hspc_pkg::RESP_SLVERR;
            case (araddr)
                hspc_pkg::ADDR_FUNC: d.rdata = {16'h0000, q.func};
                hspc_pkg::ADDR_SP1: d.rdata = {16'h0000, q.sp[0]};
                hspc_pkg::ADDR_CMP1_HI: d.rdata = {16'h0000, q.hi[0]};
                hspc_pkg::ADDR_SP2: d.rdata = {16'h0000, q.sp[1]};
                hspc_pkg::ADDR_CMP2_HI: d.rdata = {16'h0000, q.hi[1]};
                hspc_pkg::ADDR_CNT1: d.rdata = {16'h0000, q.cnt[0]};
                hspc_pkg::ADDR_CNT2: d.rdata = {16'h0000, q.cnt[1]};
                hspc_pkg::ADDR_FLAGS: d.rdata = {16'h0000, q.flags};
                hspc_pkg::ADDR_STATUS: d.rdata = {20'h00000, 2'b00, q.gate_q,
                                                  1'b0, q.sel_done, q.mode,
                                                  q.gp};
                default: d.rdata = 32'h00000000;
            endcase
        end

        // both halves present: commit the write, then answer
        if (q.aw_got && q.w_got) begin
            d.aw_got = 1'b0;
            d.w_got = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = mapped(q.aw_addr) ? hspc_pkg::RESP_OKAY
                                        : hspc_pkg::RESP_SLVERR;
            case (q.aw_addr)
                hspc_pkg::ADDR_FUNC: begin
                    if (!q.sel_done) begin
                        code = merge16(16'h0000, q.w_data, q.w_strb);
                        d.sel_done = 1'b1;
                        d.func = code;
                        case (code & hspc_pkg::CODE_MASK)
                            hspc_pkg::CODE_UP1: begin
                                d.mode = hspc_pkg::HSPC_MODE_UP;
                                d.chen = 2'b01;
                            end
                            hspc_pkg::CODE_UP2: begin
                                d.mode = hspc_pkg::HSPC_MODE_UP;
                                d.chen = 2'b10;
                            end
                            hspc_pkg::CODE_UP12: begin
                                d.mode = hspc_pkg::HSPC_MODE_UP;
                                d.chen = 2'b11;
                            end
                            hspc_pkg::CODE_SPD1: begin
                                d.mode = hspc_pkg::HSPC_MODE_SPEED;
                                d.chen = 2'b01;
                            end
                            hspc_pkg::CODE_SPD2: begin
                                d.mode = hspc_pkg::HSPC_MODE_SPEED;
                                d.chen = 2'b10;
                            end
                            hspc_pkg::CODE_SPD12: begin
                                d.mode = hspc_pkg::HSPC_MODE_SPEED;
                                d.chen = 2'b11;
                            end
                            hspc_pkg::CODE_QUAD: begin
                                d.mode = hspc_pkg::HSPC_MODE_QUAD;
                                d.chen = 2'b01;
                            end
                            default: begin
                                d.mode = hspc_pkg::HSPC_MODE_OFF;
                                d.chen = 2'b00;
                            end
                        endcase
                    end
                end
                // compares take writes with the gate on as well
                hspc_pkg::ADDR_SP1: d.sp[0] = merge16(q.sp[0], q.w_data,
                                                      q.w_strb);
                hspc_pkg::ADDR_CMP1_HI: d.hi[0] = merge16(q.hi[0], q.w_data,
                                                          q.w_strb);
                hspc_pkg::ADDR_SP2: d.sp[1] = merge16(q.sp[1], q.w_data,
                                                      q.w_strb);
                hspc_pkg::ADDR_CMP2_HI: d.hi[1] = merge16(q.hi[1], q.w_data,
                                                          q.w_strb);
                hspc_pkg::ADDR_FLAGS: d.flags = merge16(q.flags, q.w_data,
                                          q.w_strb) & hspc_pkg::FLAG_MASK;
                default: d.flags = q.flags;
            endcase
        end

        d.gate_q = {q.flags[hspc_pkg::F_GATE2], q.flags[hspc_pkg::F_GATE1]};
        d.preset_q = {q.flags[hspc_pkg::F_PRESET2],
                      q.flags[hspc_pkg::F_PRESET1]};

        case (q.mode)
            hspc_pkg::HSPC_MODE_UP,
            hspc_pkg::HSPC_MODE_SPEED: begin
                for (int i = 0; i < 2; i++) begin
                    gate = d.gate_q[i];
                    gate_fall = q.gate_q[i] & ~gate;
                    gate_rise = ~q.gate_q[i] & gate;
                    pre_rise = d.preset_q[i] & ~q.preset_q[i];
                    if (q.chen[i] && q.mode == hspc_pkg::HSPC_MODE_UP) begin
                        taken[i] = 1'b1;
                        taken[i+2] = 1'b1;
                        nxt = q.cnt[i] + 16'h0001;
                        if (gate_rise) begin
                            d.limit[i] = q.sp[i];
                        end
                        if (lvl[i+2] || gate_fall) begin
                            d.cnt[i] = 16'h0000;
                        end else if (gate && rise[i]) begin
                            // limit 0 matches on the step from ffff; other limits let the counter wrap at ffff
                            if (nxt == q.limit[i]) begin
                                d.cnt[i] = 16'h0000;
                                d.irq[i] = q.flags[i*8 +
                                           hspc_pkg::F_IRQEN1];
                            end else begin
                                d.cnt[i] = nxt;
                            end
                        end else if (!gate && pre_rise) begin
                            d.cnt[i] = q.sp[i];
                        end
                    end else if (q.chen[i]) begin
                        taken[i] = 1'b1;
                        if (q.sp[i][15:7] != 9'h000) begin
                            setting = hspc_pkg::SAMPLE_MAX;
                        end else if (q.sp[i][6:0] < hspc_pkg::SAMPLE_MIN) begin
                            setting = hspc_pkg::SAMPLE_MIN;
                        end else if (q.sp[i][6:0] > hspc_pkg::SAMPLE_MAX) begin
                            setting = hspc_pkg::SAMPLE_MAX;
                        end else begin
                            setting = q.sp[i][6:0];
                        end
                        if (!gate) begin
                            d.cnt[i] = 16'h0000;
                            d.acc[i] = 16'h0000;
                            d.tick[i] = '0;
                            d.per[i] = '0;
                        end else begin
                            nxt = q.acc[i] + {15'h0000, rise[i]};
                            d.acc[i] = nxt;
                            d.tick[i] = q.tick[i] + 20'h00001;
                            if (q.tick[i] == 20'(UNIT_CYCLES - 1)) begin
                                d.tick[i] = '0;
                                d.per[i] = q.per[i] + 7'h01;
                                if (q.per[i] == setting - 7'h01) begin
                                    d.per[i] = '0;
                                    d.cnt[i] = nxt;
                                    d.acc[i] = 16'h0000;
                                end
                            end
                        end
                    end
                end
            end
            hspc_pkg::HSPC_MODE_QUAD: begin
                taken = 4'b0111;
                gate = d.gate_q[0];
                gate_fall = q.gate_q[0] & ~gate;
                a_edge = lvl[0] ^ prv[0];
                b_edge = lvl[1] ^ prv[1];
                // both phases moving at once is an illegal step: skip it
                if (a_edge ^ b_edge) begin
                    if (lvl[0] ^ prv[1]) begin
                        qnxt = qcnt + 32'h00000001;
                    end else begin
                        qnxt = qcnt - 32'h00000001;
                    end
                end
                if (lvl[2] || gate_fall) begin
                    {d.cnt[1], d.cnt[0]} = 32'h00000000;
                end else if (gate) begin
                    {d.cnt[1], d.cnt[0]} = qnxt;
                    if ((a_edge ^ b_edge) && qnxt == cmp1) begin
                        d.irq[0] = q.flags[hspc_pkg::F_IRQEN1];
                    end
                    if ((a_edge ^ b_edge) && qnxt == cmp2) begin
                        d.irq[1] = q.flags[hspc_pkg::F_IRQEN2];
                    end
                end else if (d.preset_q[0] && !q.preset_q[0]) begin
                    {d.cnt[1], d.cnt[0]} = cmp1;
                end else if (d.preset_q[1] && !q.preset_q[1]) begin
                    {d.cnt[1], d.cnt[0]} = cmp2;
                end
            end
            default: taken = 4'b0000;
        endcase
        d.gp = lvl & ~taken;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule : hspc_top

// ### tb/hspc_pulse_src.sv
// pulse source standing in for the sensor or encoder
`timescale 1ns/100ps
module hspc_pulse_src (
    input wire logic aclk,
    input wire logic [1:0] mode,
    output logic a,
    output logic b
);
    // mode 0 hold, 1 single-phase pulses, 2 quad forward, 3 quad back
    logic [1:0] tick_q = 2'h0;
    logic [1:0] ph_q = 2'h0;
    logic sq_q = 1'b0;
    // a step every fourth edge keeps widths above the sync latency
    always_ff @(posedge aclk) begin
        tick_q <= (mode == 2'h0) ? 2'h0 : tick_q + 2'h1;
        if (tick_q == 2'h3 && mode == 2'h1) sq_q <= ~sq_q;
        if (tick_q == 2'h3 && mode[1]) ph_q <= ph_q + (mode[0] ? 2'h3 : 2'h1);
    end
    // gray walk: a changes first when running forward
    assign a = sq_q ^ ph_q[0] ^ ph_q[1];
    assign b = ph_q[1];
endmodule : hspc_pulse_src

// ### tb/hspc_sva.sv
// port-level checks for the fast pulse counter
`timescale 1ns/100ps
module hspc_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic ch1_count_or_phase_a_input,
    input wire logic ch2_count_or_phase_b_input,
    input wire logic ch1_reset_input,
    input wire logic ch2_reset_input,
    input wire logic [1:0] irq_program,
    input wire logic [3:0] gp_inputs
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [3:0] pins;
    logic [2:0][3:0] ph_q;
    logic [7:0] chg_q;
    assign pins = {ch2_reset_input, ch1_reset_input,
                   ch2_count_or_phase_b_input, ch1_count_or_phase_a_input};
    // history wide enough to cover the synchroniser delay
    always_ff @(posedge aclk) begin
        ph_q <= {ph_q[1:0], pins};
        chg_q <= {chg_q[6:0], |(pins[1:0] ^ ph_q[0][1:0])};
    end
    sequence s_wr_taken;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rst1_held;
        ch1_reset_input [*6];
    endsequence
    property p_irq_cause;
        |irq_program |-> |chg_q;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("irq without a count edge");
    property p_irq_pulse;
        |irq_program |=> irq_program == 2'h0;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse)
        else $error("irq longer than one cycle");
    property p_rst_hold;
        s_rst1_held |-> !irq_program[0];
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("irq with reset input held");
    property p_gp;
        (gp_inputs & ~(ph_q[0] | ph_q[1] | ph_q[2])) == 4'h0;
    endproperty
    a_gp: assert property (p_gp)
        else $error("digital input high with pin low");
    property p_wr_resp;
        s_wr_taken |-> ##2 bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response late");
    property p_b_one;
        bvalid && bready |=> !bvalid;
    endproperty
    a_b_one: assert property (p_b_one)
        else $error("write response repeated");
    property p_rd_resp;
        arvalid && arready |=> rvalid;
    endproperty
    a_rd_resp: assert property (p_rd_resp)
        else $error("read data late");
    property p_r_one;
        rvalid && rready |=> !rvalid;
    endproperty
    a_r_one: assert property (p_r_one)
        else $error("read data repeated");
    property p_unmapped;
        arvalid && arready && araddr > 8'h20 |=>
            rresp == hspc_pkg::RESP_SLVERR && rdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
    property p_rst_quiet;
        $rose(aresetn) |-> irq_program == 2'h0 && gp_inputs == 4'h0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not cleared by reset");
endmodule : hspc_sva

bind hspc_top hspc_sva hspc_sva_inst (.*);

// ### tb/hspc_tb_top.sv
// bench: register master, pulse source and scoreboard
`timescale 1ns/100ps
module hspc_tb_top;
    localparam logic [7:0] SP1 = hspc_pkg::ADDR_SP1, SP2 = hspc_pkg::ADDR_SP2;
    localparam logic [7:0] C1H = hspc_pkg::ADDR_CMP1_HI, FL = hspc_pkg::ADDR_FLAGS;
    localparam logic [7:0] C2H = hspc_pkg::ADDR_CMP2_HI, ST = hspc_pkg::ADDR_STATUS;
    localparam logic [7:0] CN1 = hspc_pkg::ADDR_CNT1, CN2 = hspc_pkg::ADDR_CNT2;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, rst1 = 1'b0, rst2 = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, seed = 32'hace0ae24, v, rdata;
    logic [1:0] smode = 2'h0, bresp, rresp, irq;
    logic awready, wready, bvalid, arready, rvalid, pa, pb;
    logic [3:0] gp;
    logic [1:0] wq[$];
    logic [33:0] rq[$];
    int miscompares = 0, checked = 0;
    int irqn[2] = '{0, 0};
    always #5 aclk = ~aclk;
    hspc_top #(.UNIT_CYCLES(40)) hspc_top_inst (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(1'b1),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
        .ch1_count_or_phase_a_input(pa), .ch2_count_or_phase_b_input(pb),
        .ch1_reset_input(rst1), .ch2_reset_input(rst2),
        .irq_program(irq), .gp_inputs(gp)
    );
    hspc_pulse_src hspc_pulse_src_inst (
        .aclk(aclk), .mode(smode), .a(pa), .b(pb)
    );
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic final_report();
        if (miscompares == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    // negedge: sample what the next rising edge takes
    always @(negedge aclk) begin
        if (aresetn && bvalid) chk({32'h0, bresp}, {32'h0, wq.pop_front()});
        if (aresetn && rvalid) chk({rresp, rdata}, rq.pop_front());
        if (irq[0]) irqn[0]++;
        if (irq[1]) irqn[1]++;
    end
    task automatic tmo();
        miscompares++;
        final_report();
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, done;
        wq.push_back(hspc_pkg::RESP_OKAY);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        done = 1'b0;
        for (int n = 0; !done; n++) begin
            @(negedge aclk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            done = bvalid;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (n > 40) tmo();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r = hspc_pkg::RESP_OKAY);
        logic ta, done;
        rq.push_back({r, d});
        araddr <= a;
        arvalid <= 1'b1;
        done = 1'b0;
        for (int n = 0; !done; n++) begin
            @(negedge aclk);
            ta = arvalid && arready;
            done = rvalid;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (n > 40) tmo();
        end
    endtask : rd
    task automatic run(input logic [1:0] m, input int cyc);
        smode <= m;
        repeat (cyc) @(posedge aclk);
        smode <= 2'h0;
        repeat (8) @(posedge aclk);
    endtask : run
    task automatic pulse_rst1();
        rst1 <= 1'b1;
        repeat (8) @(posedge aclk);
        rst1 <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask : pulse_rst1
    task automatic irqs(input int e0, input int e1);
        chk(34'(irqn[0]), 34'(e0));
        chk(34'(irqn[1]), 34'(e1));
    endtask : irqs
    task automatic boot(input logic [15:0] code);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        irqn = '{0, 0};
        wr(hspc_pkg::ADDR_FUNC, {16'h0, code});
    endtask : boot
    initial begin
        boot(hspc_pkg::CODE_UP1);
        rst2 <= 1'b1;
        repeat (6) @(posedge aclk);
        rd(ST, 32'h58);
        wr(hspc_pkg::ADDR_FUNC, 32'h1403);
        rd(ST, 32'h58);
        rst2 <= 1'b0;
        rd(8'h24, 32'h0, hspc_pkg::RESP_SLVERR);
        wr(SP1, 32'h3);
        wr(FL, 32'h3);
        wr(SP1, 32'h7);
        run(2'h1, 16);
        rd(CN1, 32'h2);
        run(2'h1, 8);
        rd(CN1, 32'h0);
        irqs(1, 0);
        run(2'h1, 16);
        pulse_rst1();
        rd(CN1, 32'h0);
        run(2'h1, 16);
        wr(FL, 32'h0);
        rd(CN1, 32'h0);
        seed = xs(seed);
        v = {16'h0, seed[15:0]};
        wr(SP1, v);
        wr(FL, 32'h8);
        rd(CN1, v);
        wr(FL, 32'h1);
        wr(SP1, ~v & 32'hffff);
        wr(FL, 32'h9);
        rd(CN1, v);
        boot(hspc_pkg::CODE_SPD1);
        wr(SP1, 32'h2);
        rd(CN1, 32'h0);
        wr(FL, 32'h1);
        smode <= 2'h1;
        repeat (320) @(posedge aclk);
        rd(CN1, 32'ha);
        smode <= 2'h0;
        wr(FL, 32'h0);
        rd(CN1, 32'h0);
        irqs(0, 0);
        boot(hspc_pkg::CODE_QUAD);
        wr(SP1, 32'h8);
        wr(SP2, 32'hfffc);
        wr(C2H, 32'hffff);
        wr(FL, 32'h203);
        run(2'h2, 32);
        rd(CN1, 32'h8);
        run(2'h3, 48);
        rd(CN1, 32'hfffc);
        rd(CN2, 32'hffff);
        irqs(1, 1);
        wr(C1H, 32'hffff);
        wr(SP1, 32'hfff8);
        run(2'h3, 16);
        irqs(2, 1);
        pulse_rst1();
        rd(CN2, 32'h0);
        wr(FL, 32'h0);
        wr(FL, 32'h800);
        rd(CN2, 32'hffff);
        final_report();
    end
endmodule : hspc_tb_top
